// [timer_ctl_pkg.sv]
package timer_ctl_pkg;

    // register map (byte addresses)
    localparam logic [11:0] addr_control = 12'h000;
    localparam logic [11:0] addr_count   = 12'h004;
    localparam logic [11:0] addr_period  = 12'h008;
    localparam logic [11:0] addr_status  = 12'h00C;

    // control field positions
    localparam int bit_run       = 15;
    localparam int bit_idle_halt = 13;
    localparam int bit_gate      = 6;
    localparam int bit_ps_hi     = 5;
    localparam int bit_ps_lo     = 4;
    localparam int bit_clk_src   = 1;

    // writable bits of the control register and its reset value
    localparam logic [15:0] control_mask  = 16'hA072;
    localparam logic [15:0] control_reset = 16'h0000;
    localparam logic [15:0] period_reset  = 16'hFFFF;

    // prescale encodings and terminal counts (ratio minus one)
    localparam logic [1:0] ps_1   = 2'h0;
    localparam logic [1:0] ps_8   = 2'h1;
    localparam logic [1:0] ps_64  = 2'h2;
    localparam logic [1:0] ps_256 = 2'h3;
    localparam logic [7:0] ps_term_1   = 8'h00;
    localparam logic [7:0] ps_term_8   = 8'h07;
    localparam logic [7:0] ps_term_64  = 8'h3F;
    localparam logic [7:0] ps_term_256 = 8'hFF;

    // decoded control settings
    typedef struct packed {
        logic       run;
        logic       idle_halt;
        logic       gate;
        logic [1:0] prescale;
        logic       clk_src;
    } control_type;

endpackage : timer_ctl_pkg

// [prescaler.sv]
`timescale 1ns/100ps
`default_nettype none

// divides a tick stream by 1, 8, 64 or 256
module prescaler (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // control
    input  wire logic       clear_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       tick_i,
    // divided tick
    output logic            tick_o
);

    logic [7:0] count;
    logic [7:0] term;

    // terminal count per ratio
    always_comb begin
        case (sel_i)
            timer_ctl_pkg::ps_8:   term = timer_ctl_pkg::ps_term_8;
            timer_ctl_pkg::ps_64:  term = timer_ctl_pkg::ps_term_64;
            timer_ctl_pkg::ps_256: term = timer_ctl_pkg::ps_term_256;
            default:               term = timer_ctl_pkg::ps_term_1;
        endcase
    end

    assign tick_o = tick_i && (count == term);

    // ratio counter
    always_ff @(posedge clk_i) begin
        if (!rstn_i || clear_i) begin
            count <= 8'h00;
        end else if (tick_i) begin
            count <= (count == term) ? 8'h00 : count + 8'h01;
        end
    end

endmodule : prescaler
`default_nettype wire

// [timer_control.sv]
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module timer_control (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // device and pins
    input  wire logic        idle_mode_i,
    input  wire logic        pair_wide_mode_i,
    input  wire logic        internal_tick_i,
    input  wire logic        ext_clock_pin_i,
    input  wire logic        gate_pin_i,
    // timer outputs
    output logic      [15:0] count_o,
    output logic             period_match_o
);

    logic [15:0] timer_control;
    logic [15:0] period;
    logic        ext_prev;
    logic        match_flag;
    timer_ctl_pkg::control_type ctl;
    logic        wr_en;
    logic        src_tick;
    logic        pre_tick;
    logic        running;
    logic        ps_clear;
    logic [15:0] next_count;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign pready_o = 1'b1;
    assign wr_en    = psel_i && penable_i && pwrite_i;

    // unmapped addresses answer with an error
    always_comb begin
        if (paddr_i == timer_ctl_pkg::addr_control) begin
            pslverr_o = 1'b0;
        end else if (paddr_i == timer_ctl_pkg::addr_count) begin
            pslverr_o = 1'b0;
        end else if (paddr_i == timer_ctl_pkg::addr_period) begin
            pslverr_o = 1'b0;
        end else if (paddr_i == timer_ctl_pkg::addr_status) begin
            pslverr_o = 1'b0;
        end else begin
            pslverr_o = psel_i && penable_i;
        end
    end

    // control register, unimplemented bits held at zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            timer_control <= timer_ctl_pkg::control_reset;
        end else if (wr_en && paddr_i == timer_ctl_pkg::addr_control) begin
            timer_control <= pwdata_i[15:0] & timer_ctl_pkg::control_mask;
        end
    end

    // period register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            period <= timer_ctl_pkg::period_reset;
        end else if (wr_en && paddr_i == timer_ctl_pkg::addr_period) begin
            period <= pwdata_i[15:0];
        end
    end

    // read data register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            if (paddr_i == timer_ctl_pkg::addr_control) begin
                prdata_o <= {16'h0000, timer_control};
            end else if (paddr_i == timer_ctl_pkg::addr_count) begin
                prdata_o <= {16'h0000, count_o};
            end else if (paddr_i == timer_ctl_pkg::addr_period) begin
                prdata_o <= {16'h0000, period};
            end else if (paddr_i == timer_ctl_pkg::addr_status) begin
                prdata_o <= {30'h0000_0000, pair_wide_mode_i, match_flag};
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control fields; wide mode masks all but idle-halt
    always_comb begin
        ctl.idle_halt = timer_control[timer_ctl_pkg::bit_idle_halt];
        if (pair_wide_mode_i) begin
            ctl.run      = 1'b0;
            ctl.gate     = 1'b0;
            ctl.prescale = timer_ctl_pkg::ps_1;
            ctl.clk_src  = 1'b0;
        end else begin
            ctl.run      = timer_control[timer_ctl_pkg::bit_run];
            ctl.gate     = timer_control[timer_ctl_pkg::bit_gate];
            ctl.prescale = timer_control[timer_ctl_pkg::bit_ps_hi:
                                         timer_ctl_pkg::bit_ps_lo];
            ctl.clk_src  = timer_control[timer_ctl_pkg::bit_clk_src];
        end
    end

    // external pin edge history
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_clock_pin_i;
        end
    end

    // source selection and gating
    always_comb begin
        if (ctl.clk_src) begin
            src_tick = ext_clock_pin_i && !ext_prev; // gate ignored
        end else if (ctl.gate) begin
            src_tick = internal_tick_i && gate_pin_i;
        end else begin
            src_tick = internal_tick_i;
        end
    end

    // stop when off or when halted in idle
    assign running  = ctl.run && !(ctl.idle_halt && idle_mode_i);
    // a control write restarts the ratio so a new setting starts clean
    assign ps_clear = !ctl.run
                      || (wr_en && paddr_i == timer_ctl_pkg::addr_control);

    prescaler u_prescaler (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .clear_i (ps_clear),
        .sel_i   (ctl.prescale),
        .tick_i  (src_tick && running),
        .tick_o  (pre_tick)
    );

    // counter with period wrap
    always_comb begin
        next_count = count_o;
        if (pre_tick) begin
            next_count = (count_o == period) ? 16'h0000 : count_o + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            count_o <= 16'h0000;
        end else if (wr_en && paddr_i == timer_ctl_pkg::addr_count) begin
            count_o <= pwdata_i[15:0];
        end else begin
            count_o <= next_count;
        end
    end

    assign period_match_o = pre_tick && (count_o == period);

    // sticky match flag, set beats a write-one clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            match_flag <= 1'b0;
        end else if (period_match_o) begin
            match_flag <= 1'b1;
        end else if (wr_en && paddr_i == timer_ctl_pkg::addr_status
                     && pwdata_i[0]) begin
            match_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_stopped;
        @(posedge clk_i) disable iff (!rstn_i)
        (!ctl.run && !(wr_en && paddr_i == timer_ctl_pkg::addr_count))
            |=> count_o == $past(count_o);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while off");

    property p_idle_halt;
        @(posedge clk_i) disable iff (!rstn_i)
        (idle_mode_i && ctl.idle_halt) |-> !pre_tick;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("ticked in idle halt");

    property p_idle_run;
        @(posedge clk_i) disable iff (!rstn_i)
        (ctl.run && !ctl.idle_halt && !ctl.clk_src && !ctl.gate
         && ctl.prescale == timer_ctl_pkg::ps_1 && internal_tick_i) |-> pre_tick;
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("missed tick");

    property p_gate;
        @(posedge clk_i) disable iff (!rstn_i)
        (!ctl.clk_src && ctl.gate && !gate_pin_i) |-> !pre_tick;
    endproperty
    a_gate: assert property (p_gate) else $error("tick with gate low");

    property p_ext;
        @(posedge clk_i) disable iff (!rstn_i)
        (ctl.clk_src && running && ctl.prescale == timer_ctl_pkg::ps_1
         && ext_clock_pin_i && !ext_prev) |-> pre_tick;
    endproperty
    a_ext: assert property (p_ext) else $error("external edge lost");

    // input ticks taken since the last divided tick, for the ratio check
    logic [7:0] ps_seen;
    always_ff @(posedge clk_i) begin
        if (!rstn_i || ps_clear || pre_tick) begin
            ps_seen <= 8'h00;
        end else if (src_tick && running) begin
            ps_seen <= ps_seen + 8'h01;
        end
    end

    property p_ps8;
        @(posedge clk_i) disable iff (!rstn_i)
        (pre_tick && ctl.prescale == timer_ctl_pkg::ps_8)
            |-> ps_seen == timer_ctl_pkg::ps_term_8;
    endproperty
    a_ps8: assert property (p_ps8) else $error("1:8 ratio wrong");

    property p_wide;
        @(posedge clk_i) disable iff (!rstn_i)
        pair_wide_mode_i |-> !pre_tick;
    endproperty
    a_wide: assert property (p_wide) else $error("ran in wide mode");

    property p_reset;
        @(posedge clk_i)
        !rstn_i |=> timer_control == 16'h0000 && count_o == 16'h0000;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset value");

    c_match: cover property (@(posedge clk_i) period_match_o);
    c_ext:   cover property (@(posedge clk_i) ctl.clk_src && pre_tick);
    c_gate:  cover property (@(posedge clk_i) ctl.gate && pre_tick);

endmodule : timer_control
`default_nettype wire

// [timer_type_c_control_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module timer_type_c_control_tb_top;

    logic        clk_i;
    logic        rstn_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idle_mode;
    logic        wide;
    logic        tick;
    logic        ext_pin;
    logic        gate_pin;
    logic [15:0] count;
    logic        match;
    int          errors;
    int          samples_checked;
    int          cycles;

    timer_control u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .idle_mode_i(idle_mode), .pair_wide_mode_i(wide),
        .internal_tick_i(tick), .ext_clock_pin_i(ext_pin),
        .gate_pin_i(gate_pin), .count_o(count), .period_match_o(match)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare, verdict and bus tasks
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        // only the bench timeout ends a hang here
        while (pready !== 1'b1) begin
            @(posedge clk_i);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // clear count, run with given control, feed n units, read count
    task automatic run_case(input logic [15:0] ctrl, input int n,
                            input logic use_ext, output logic [31:0] r);
        logic        e;
        logic [31:0] d;
        apb(1'b1, timer_ctl_pkg::addr_count, 32'h00000000, r, e);
        apb(1'b1, timer_ctl_pkg::addr_control, {16'h0000, ctrl}, r, e);
        repeat (n) begin
            @(posedge clk_i);
            tick    <= 1'b1;
            ext_pin <= use_ext;
            @(posedge clk_i);
            tick    <= use_ext;
            ext_pin <= 1'b0;
        end
        @(posedge clk_i);
        tick <= 1'b0;
        repeat (4) @(posedge clk_i);
        apb(1'b0, timer_ctl_pkg::addr_count, 32'h00000000, r, e);
        apb(1'b1, timer_ctl_pkg::addr_control, 32'h00000000, d, e);
    endtask : run_case

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        check("ready", {31'h0, pready}, 32'h00000001);
        apb(1'b0, timer_ctl_pkg::addr_control, 32'h0, r, e);
        check("control reset", r, 32'h00000000);
        apb(1'b0, timer_ctl_pkg::addr_period, 32'h0, r, e);
        check("period reset", r, 32'h0000FFFF);
        apb(1'b1, timer_ctl_pkg::addr_control, 32'hFFFFFFFF, r, e);
        apb(1'b0, timer_ctl_pkg::addr_control, 32'h0, r, e);
        check("control bits", r, 32'h0000A072);
        apb(1'b0, 12'h010, 32'h0, r, e);
        check("unmapped data", r, 32'h00000000);
        check("unmapped err", {31'h0, e}, 32'h00000001);
        apb(1'b1, timer_ctl_pkg::addr_control, 32'h0, r, e);
    endtask : t_regs

    task automatic t_prescale();
        logic [31:0] r;
        int          div [4] = '{1, 8, 64, 256};
        for (int i = 0; i < 4; i++) begin
            run_case(16'h8000 | 16'(i << 4), 2 * div[i], 1'b0, r);
            check("prescaled count", r, 32'h00000002);
        end
    endtask : t_prescale

    task automatic t_run_gate_src();
        logic [31:0] r;
        run_case(16'h0000, 4, 1'b0, r);
        check("stopped count", r, 32'h00000000);
        run_case(16'h8000, 4, 1'b0, r);
        check("running count", r, 32'h00000004);
        run_case(16'h8002, 3, 1'b1, r);
        check("ext count", r, 32'h00000003);
        run_case(16'h8042, 3, 1'b1, r);
        check("ext gate ignored", r, 32'h00000003);
        run_case(16'h8040, 4, 1'b0, r);
        check("gate low", r, 32'h00000000);
        @(posedge clk_i);
        gate_pin <= 1'b1;
        run_case(16'h8040, 4, 1'b0, r);
        check("gate high", r, 32'h00000004);
    endtask : t_run_gate_src

    task automatic t_idle_wide();
        logic [31:0] r;
        logic        e;
        @(posedge clk_i);
        idle_mode <= 1'b1;
        run_case(16'hA000, 4, 1'b0, r);
        check("idle halted", r, 32'h00000000);
        run_case(16'h8000, 4, 1'b0, r);
        check("idle running", r, 32'h00000004);
        @(posedge clk_i);
        idle_mode <= 1'b0;
        wide      <= 1'b1;
        run_case(16'h8000, 4, 1'b0, r);
        check("wide internal", r, 32'h00000000);
        run_case(16'h8002, 3, 1'b1, r);
        check("wide ext", r, 32'h00000000);
        // software keeps idle-halt clear while the pair runs wide
        apb(1'b1, timer_ctl_pkg::addr_control, 32'h00008000, r, e);
        apb(1'b0, timer_ctl_pkg::addr_control, 32'h0, r, e);
        check("wide idle-halt clear", r, 32'h00008000);
        apb(1'b0, timer_ctl_pkg::addr_status, 32'h0, r, e);
        check("wide status", r, 32'h00000002);
        apb(1'b1, timer_ctl_pkg::addr_control, 32'h0, r, e);
        @(posedge clk_i);
        wide <= 1'b0;
    endtask : t_idle_wide

    // period wrap, match pulse on the pin and sticky flag
    task automatic t_period();
        logic [31:0] r;
        logic        e;
        apb(1'b1, timer_ctl_pkg::addr_period, 32'h00000002, r, e);
        apb(1'b1, timer_ctl_pkg::addr_count, 32'h00000000, r, e);
        apb(1'b1, timer_ctl_pkg::addr_control, 32'h00008000, r, e);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(negedge clk_i);
            check("match pulse", {31'h0, match}, {31'h0, k == 2});
            @(posedge clk_i);
            tick <= 1'b0;
        end
        @(negedge clk_i);
        check("match after", {31'h0, match}, 32'h00000000);
        check("count pin wrapped", {16'h0, count}, 32'h00000000);
        apb(1'b0, timer_ctl_pkg::addr_status, 32'h0, r, e);
        check("match flag", r, 32'h00000001);
        apb(1'b1, timer_ctl_pkg::addr_status, 32'h00000001, r, e);
        apb(1'b0, timer_ctl_pkg::addr_status, 32'h0, r, e);
        check("match flag cleared", r, 32'h00000000);
        apb(1'b1, timer_ctl_pkg::addr_control, 32'h0, r, e);
    endtask : t_period

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {idle_mode, wide, tick, ext_pin, gate_pin} = '0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_prescale();
        t_run_gate_src();
        t_idle_wide();
        t_period();
        wrap_up();
    end

endmodule : timer_type_c_control_tb_top

`default_nettype wire
